// ===== hw/xds_pkg.sv
package xds_pkg;

   // Register byte offsets
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_ACCESS = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;

   // Config field positions
   localparam int CFG_STRETCH_LSB = 0;
   localparam int CFG_PAGE_TS_LSB = 3;
   localparam int CFG_PAGE_EN_BIT = 5;
   localparam int CFG_DIV_LSB     = 6;
   localparam int CFG_MULT_BIT    = 8;
   localparam logic [8:0] CFG_RESET = 9'h080;

   // Access field positions
   localparam int ACC_ADDR_LSB  = 0;
   localparam int ACC_WDATA_LSB = 16;
   localparam int ACC_WRITE_BIT = 24;

   // Status field positions
   localparam int STS_BUSY_BIT   = 0;
   localparam int STS_HIT_BIT    = 1;
   localparam int STS_RDATA_LSB  = 8;
   localparam int STS_STROBE_LSB = 16;

   // System clock divider, in hclk cycles per system clock
   localparam logic [1:0] DIV_QUARTER = 2'b00;
   localparam logic [1:0] DIV_ONE     = 2'b10;
   localparam logic [1:0] DIV_SLOW    = 2'b11;
   localparam logic [12:0] HCLK_PER_SYS_4X = 13'h0001;
   localparam logic [12:0] HCLK_PER_SYS_2X = 13'h0002;
   localparam logic [12:0] HCLK_PER_SYS_1X = 13'h0004;
   localparam int HCLK_PER_SYS_SLOW = 4096;

   // Phase lengths, in system clocks
   localparam logic [5:0] SYS_PER_STRETCH = 6'h04;
   localparam logic [5:0] ONE_SYS         = 6'h01;
   localparam logic [5:0] NO_SYS          = 6'h00;
   localparam logic [1:0] PTS_FAST  = 2'b00;
   localparam logic [1:0] PTS_TWO   = 2'b01;
   localparam logic [1:0] PTS_FOUR  = 2'b10;
   localparam logic [1:0] PTS_MUX   = 2'b11;
   localparam logic [5:0] MUX_DATA_HALF = 6'h02;
   localparam logic [2:0] SLOW_GROUP = 3'h4;

   typedef enum logic [2:0] {
      PH_IDLE, PH_LATCH, PH_SETUP, PH_STROBE, PH_HOLD
   } xds_phase_e;

   // Stretch cycles per select code: three timing groups
   function automatic logic [5:0] stretch_cycles(input logic [2:0] code);
      stretch_cycles = (code >= SLOW_GROUP) ? {3'h0, code} + 6'h03 : {3'h0, code};
   endfunction

   // Page-hit memory cycle in system clocks
   function automatic logic [5:0] hit_len(input logic [1:0] pts);
      unique case (pts)
         PTS_FAST: hit_len = 6'h01;
         PTS_TWO:  hit_len = 6'h02;
         PTS_FOUR: hit_len = 6'h04;
         PTS_MUX:  hit_len = MUX_DATA_HALF;
      endcase
   endfunction

   // Read/write strobe low time in system clocks
   function automatic logic [5:0] strobe_len(input logic [2:0] code, input logic [1:0] pts);
      logic [5:0] four_n;
      four_n = SYS_PER_STRETCH * stretch_cycles(code) - ((code >= SLOW_GROUP) ? 6'h0c : 6'h00);
      if (pts[1])
         strobe_len = (code == 3'h0) ? 6'h02 : four_n;
      else
         strobe_len = (code == 3'h0) ? 6'h01 : four_n - ONE_SYS;
   endfunction

   // Added address setup / data float before the strobe
   function automatic logic [5:0] setup_len(input logic [2:0] code, input logic [1:0] pts);
      logic [5:0] base;
      base = pts[1] ? ONE_SYS : NO_SYS;
      if (code >= SLOW_GROUP)
         setup_len = base + SYS_PER_STRETCH * 6'h02;
      else if (code != 3'h0)
         setup_len = base + ONE_SYS;
      else
         setup_len = base;
   endfunction

   // Address and data hold after the strobe
   function automatic logic [5:0] hold_len(input logic [2:0] code);
      if (code >= SLOW_GROUP)
         hold_len = ONE_SYS + SYS_PER_STRETCH;
      else if (code != 3'h0)
         hold_len = ONE_SYS + ONE_SYS;
      else
         hold_len = ONE_SYS;
   endfunction

endpackage

// ===== hw/xds_sysclk_div.sv
`timescale 1ns/100ps
module xds_sysclk_div #(
   parameter int SLOW_PERIOD = xds_pkg::HCLK_PER_SYS_SLOW
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [1:0] clock_divide_select,
   input  wire logic       clock_multiply_select,
   output logic            sys_tick
);

   logic [12:0] cnt_r;
   logic [12:0] period;

   // Hclk is the 4x rate, so every slower system clock is a tick
   always_comb begin
      if (clock_divide_select == xds_pkg::DIV_SLOW)
         period = 13'(SLOW_PERIOD);
      else if (clock_divide_select == xds_pkg::DIV_ONE)
         period = xds_pkg::HCLK_PER_SYS_1X;
      else if (clock_divide_select == xds_pkg::DIV_QUARTER && clock_multiply_select)
         period = xds_pkg::HCLK_PER_SYS_4X;
      else
         period = xds_pkg::HCLK_PER_SYS_2X;
   end

   // Counter restarts on wrap; a setting change takes hold at the next wrap or sooner
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r    <= 13'h0000;
         sys_tick <= 1'b0;
      end else if (cnt_r + 13'h0001 >= period) begin
         cnt_r    <= 13'h0000;
         sys_tick <= 1'b1; // see (RULE10)
      end else begin
         cnt_r    <= cnt_r + 13'h0001;
         sys_tick <= 1'b0;
      end
   end

endmodule

// ===== hw/xds_top.sv
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
// How it works
// (RULE1) Stretch applies in page mode as non-page
// (RULE2) Each stretch cycle is four system clocks
// (RULE3) Select codes map to 0,1,2,3,7,8,9,10 stretches
// (RULE4) Code zero: no stretch, two basic cycles
// (RULE5) Codes one to three add that many stretches
// (RULE6) Stretch one adds one setup, one hold clock
// (RULE7) Slow codes: two setup, one hold, wider latch
// (RULE8) Fast page modes strobe 1,3,7..27 clocks
// (RULE9) Slow page modes strobe 2,4,8..28 clocks
// (RULE10) Clock setting scales strobe in oscillator clocks
// (RULE11) Page hit cycle shorter than page miss
// (RULE12) Multiplexed page mode uses four-clock data cycle
// (RULE13) Upper address byte change means page miss
// (RULE14) Address latch strobe only on page miss
// (RULE15) Outside parts must meet resulting access timing
// (RULE16) Settings sampled at start of each move; here only stretch and page settings are, the divider setting acts at once
module xds_top #(
   parameter int SLOW_PERIOD = xds_pkg::HCLK_PER_SYS_SLOW
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [15:0]      ext_addr,
   output logic             ext_latch,
   output logic             ext_rd_n,
   output logic             ext_wr_n,
   output logic [7:0]       ext_data_out,
   output logic             ext_data_oe,
   input  wire logic [7:0]  ext_data_in
);

   // Upper address byte position inside the access word
   localparam int ACC_HI_LSB = xds_pkg::ACC_ADDR_LSB + 8;

   // Enum alias kept local so the port list stays plain
   typedef xds_pkg::xds_phase_e xds_phase_e_alias_t;
   localparam xds_phase_e_alias_t PH_IDLE   = xds_pkg::PH_IDLE;
   localparam xds_phase_e_alias_t PH_LATCH  = xds_pkg::PH_LATCH;
   localparam xds_phase_e_alias_t PH_SETUP  = xds_pkg::PH_SETUP;
   localparam xds_phase_e_alias_t PH_STROBE = xds_pkg::PH_STROBE;
   localparam xds_phase_e_alias_t PH_HOLD   = xds_pkg::PH_HOLD;

   // Software settings
   logic [2:0]  stretch_select_r;
   logic [1:0]  page_timing_select_r;
   logic        page_bus_enable_r;
   logic [1:0]  clock_divide_select_r;
   logic        clock_multiply_select_r;

   // Bus slave data-phase state
   logic        dp_write_r;
   logic [7:0]  dp_addr_r;

   // Move in progress
   xds_phase_e_alias_t phase_r;
   logic [5:0]  cnt_r;
   logic [5:0]  setup_r;
   logic [5:0]  strobe_r;
   logic [5:0]  hold_r;
   logic        move_write_r;
   logic [15:0] move_addr_r;
   logic [7:0]  move_wdata_r;
   logic [7:0]  last_page_r;
   logic        page_valid_r;
   logic        last_hit_r;
   logic [7:0]  rdata_r;
   logic [5:0]  last_strobe_r;

   // Divider tick, launch and next-state terms
   logic        sys_tick;
   logic        launch;
   logic        miss;
   logic        phase_end;
   logic [2:0]  code;
   logic [1:0]  pts;
   logic [5:0]  latch_len;
   xds_phase_e_alias_t phase_nxt;
   logic [5:0]  cnt_nxt;

   xds_sysclk_div #(
      .SLOW_PERIOD (SLOW_PERIOD)
   ) u_div (
      .hclk                  (hclk),
      .hresetn               (hresetn),
      .clock_divide_select   (clock_divide_select_r),
      .clock_multiply_select (clock_multiply_select_r),
      .sys_tick              (sys_tick)
   );

   // Address phase capture; zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_r <= 1'b0;
         dp_addr_r  <= 8'h00;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end else begin
         dp_write_r <= hsel && hready && htrans[1] && hwrite;
         dp_addr_r  <= haddr[7:0];
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end
   end

   // Read data registered at the address phase so hrdata is a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         unique case (haddr[7:0])
            xds_pkg::REG_CONFIG:
               hrdata <= {23'h000000, clock_multiply_select_r, clock_divide_select_r,
                          page_bus_enable_r, page_timing_select_r, stretch_select_r};
            xds_pkg::REG_ACCESS:
               hrdata <= {7'h00, move_write_r, move_wdata_r, move_addr_r};
            xds_pkg::REG_STATUS:
               hrdata <= {10'h000, last_strobe_r, rdata_r, 6'h00, last_hit_r,
                          phase_r != PH_IDLE};
            default:
               hrdata <= 32'h00000000;
         endcase
      end
   end

   // Configuration register; live stretch and page values only reach a move at its start
   // Divider setting acts at once, stretch and page timing only at launch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stretch_select_r        <= xds_pkg::CFG_RESET[2:0];
         page_timing_select_r    <= xds_pkg::CFG_RESET[4:3];
         page_bus_enable_r       <= xds_pkg::CFG_RESET[5];
         clock_divide_select_r   <= xds_pkg::CFG_RESET[7:6];
         clock_multiply_select_r <= xds_pkg::CFG_RESET[8];
      end else if (dp_write_r && dp_addr_r == xds_pkg::REG_CONFIG) begin
         stretch_select_r        <= hwdata[xds_pkg::CFG_STRETCH_LSB +: 3];
         page_timing_select_r    <= hwdata[xds_pkg::CFG_PAGE_TS_LSB +: 2];
         page_bus_enable_r       <= hwdata[xds_pkg::CFG_PAGE_EN_BIT];
         clock_divide_select_r   <= hwdata[xds_pkg::CFG_DIV_LSB +: 2];
         clock_multiply_select_r <= hwdata[xds_pkg::CFG_MULT_BIT];
      end
   end

   // A write to the access register starts a move; ignored while busy
   assign launch = dp_write_r && dp_addr_r == xds_pkg::REG_ACCESS && phase_r == PH_IDLE;
   assign code   = stretch_select_r;
   assign pts    = page_timing_select_r;

   // Non-page mode latches every address, page mode only on a new upper byte or the first move after reset
   assign miss = !page_bus_enable_r || !page_valid_r ||
                 hwdata[ACC_HI_LSB +: 8] != last_page_r; // see (RULE13)

   // Latch strobe is the first half of a miss cycle, widened for slow codes
   assign latch_len = xds_pkg::hit_len(pts) +
                      ((code >= xds_pkg::SLOW_GROUP) ? xds_pkg::SYS_PER_STRETCH
                                                     : xds_pkg::NO_SYS); // see (RULE7) (RULE12)

   // Lengths captured once per move
   // Later stretch or page setting writes can neither stretch nor cut a move under way
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         setup_r      <= 6'h00;
         strobe_r     <= 6'h01;
         hold_r       <= 6'h01;
         move_write_r <= 1'b0;
         move_addr_r  <= 16'h0000;
         move_wdata_r <= 8'h00;
      end else if (launch) begin
         setup_r      <= xds_pkg::setup_len(code, pts);  // see (RULE6) (RULE7) (RULE16)
         strobe_r     <= xds_pkg::strobe_len(code, pts); // see (RULE2) (RULE3) (RULE8) (RULE9)
         hold_r       <= xds_pkg::hold_len(code);        // see (RULE1) (RULE4) (RULE5)
         move_write_r <= hwdata[xds_pkg::ACC_WRITE_BIT];
         move_addr_r  <= hwdata[xds_pkg::ACC_ADDR_LSB +: 16];
         move_wdata_r <= hwdata[xds_pkg::ACC_WDATA_LSB +: 8];
      end
   end

   // A phase ends on the tick that finds one count left
   assign phase_end = sys_tick && cnt_r == xds_pkg::ONE_SYS;

   // Phase sequencing; zero-length setup is skipped
   // Latch only on a miss, so a hit goes straight to setup or strobe
   always_comb begin
      phase_nxt = phase_r;
      cnt_nxt   = phase_end ? cnt_r : cnt_r - {5'h00, sys_tick};
      unique case (phase_r)
         PH_IDLE: begin
            cnt_nxt = cnt_r;
            if (launch) begin
               if (miss) begin
                  phase_nxt = PH_LATCH; // see (RULE11) (RULE14)
                  cnt_nxt   = latch_len;
               end else if (xds_pkg::setup_len(code, pts) != xds_pkg::NO_SYS) begin
                  phase_nxt = PH_SETUP;
                  cnt_nxt   = xds_pkg::setup_len(code, pts);
               end else begin
                  phase_nxt = PH_STROBE;
                  cnt_nxt   = xds_pkg::strobe_len(code, pts);
               end
            end
         end
         PH_LATCH: begin
            if (phase_end) begin
               phase_nxt = (setup_r != xds_pkg::NO_SYS) ? PH_SETUP : PH_STROBE;
               cnt_nxt   = (setup_r != xds_pkg::NO_SYS) ? setup_r : strobe_r;
            end
         end
         PH_SETUP: begin
            if (phase_end) begin
               phase_nxt = PH_STROBE;
               cnt_nxt   = strobe_r;
            end
         end
         PH_STROBE: begin
            if (phase_end) begin
               phase_nxt = PH_HOLD;
               cnt_nxt   = hold_r;
            end
         end
         PH_HOLD: begin
            if (phase_end) begin
               phase_nxt = PH_IDLE;
               cnt_nxt   = xds_pkg::NO_SYS;
            end
         end
         default: begin
            phase_nxt = PH_IDLE;
            cnt_nxt   = xds_pkg::NO_SYS;
         end
      endcase
   end

   // Phase register; apart from the load at launch, the counter only moves on ticks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_r <= PH_IDLE;
         cnt_r   <= 6'h00;
      end else begin
         phase_r <= phase_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Page tracking; first move after reset always misses
   // Writes refused while busy leave the page untouched
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_page_r  <= 8'h00;
         page_valid_r <= 1'b0;
         last_hit_r   <= 1'b0;
      end else if (launch) begin
         last_page_r  <= hwdata[ACC_HI_LSB +: 8]; // see (RULE13)
         page_valid_r <= 1'b1;
         last_hit_r   <= !miss;
      end
   end

   // Read data taken on the last tick of the strobe, before it rises
   // Writes keep the old byte so status still shows the last read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r       <= 8'h00;
         last_strobe_r <= 6'h00;
      end else if (phase_r == PH_STROBE && phase_end) begin
         rdata_r       <= move_write_r ? rdata_r : ext_data_in;
         last_strobe_r <= strobe_r;
      end
   end

   // Pins follow the next phase so they are flops aligned with the phase
   // A slow part must fit its access time inside the strobe chosen here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_addr     <= 16'h0000;
         ext_latch    <= 1'b0;
         ext_rd_n     <= 1'b1;
         ext_wr_n     <= 1'b1;
         ext_data_out <= 8'h00;
         ext_data_oe  <= 1'b0;
      end else begin
         ext_addr     <= launch ? hwdata[xds_pkg::ACC_ADDR_LSB +: 16] : ext_addr;
         ext_latch    <= phase_nxt == PH_LATCH; // see (RULE14)
         // At launch the strobes take the write flag straight from the bus
         ext_rd_n     <= !(phase_nxt == PH_STROBE && !(launch ? hwdata[xds_pkg::ACC_WRITE_BIT]
                                                              : move_write_r));
         ext_wr_n     <= !(phase_nxt == PH_STROBE && (launch ? hwdata[xds_pkg::ACC_WRITE_BIT]
                                                             : move_write_r));
         ext_data_out <= launch ? hwdata[xds_pkg::ACC_WDATA_LSB +: 8] : ext_data_out;
         // Data bus floats during latch, driven through hold on writes
         ext_data_oe  <= (launch ? hwdata[xds_pkg::ACC_WRITE_BIT] : move_write_r) &&
                         (phase_nxt == PH_SETUP || phase_nxt == PH_STROBE ||
                          phase_nxt == PH_HOLD);
      end
   end

endmodule

// ===== sim/test_ext_data_bus_stretch_paged.sv
`timescale 1ns/100ps
module test_ext_data_bus_stretch_paged;
   localparam int SP = 8;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0]  dly = 8'h00;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, ext_latch, ext_rd_n, ext_wr_n, ext_data_oe;
   logic [15:0] ext_addr;
   logic [7:0]  ext_data_out, ext_data_in;
   integer      seed = 32'hd8ea;
   int          mismatches = 0;
   int          num_checks = 0;
   int          low_cnt = 0, last_w = 0, latch_cnt = 0, act_cnt = 0, lat_cnt = 0, last_l = 0;
   logic        latch_q = 1'b0;
   logic [7:0]  page = 8'h00;

   // Clock
   always #2.5 hclk = ~hclk;

   xds_top #(.SLOW_PERIOD(SP)) u_xds_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ext_addr(ext_addr), .ext_latch(ext_latch), .ext_rd_n(ext_rd_n),
      .ext_wr_n(ext_wr_n), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
      .ext_data_in(ext_data_in));

   xds_ext_ram u_xds_ext_ram (
      .hclk(hclk), .ext_addr(ext_addr), .ext_latch(ext_latch), .ext_rd_n(ext_rd_n),
      .ext_wr_n(ext_wr_n), .ext_data_out(ext_data_out), .delay(dly), .ext_data_in(ext_data_in));

   // Pin monitor: strobe width, latch pulses, busy cycles on the bus
   always @(posedge hclk) begin
      latch_q <= ext_latch;
      if (ext_latch && !latch_q) latch_cnt <= latch_cnt + 1;
      if (ext_latch || ext_data_oe || !ext_wr_n || !ext_rd_n) act_cnt <= act_cnt + 1;
      if (!ext_rd_n || !ext_wr_n) low_cnt <= low_cnt + 1;
      else if (low_cnt != 0) begin
         last_w <= low_cnt;
         low_cnt <= 0;
      end
      if (ext_latch) lat_cnt <= lat_cnt + 1;
      else if (lat_cnt != 0) begin
         last_l <= lat_cnt;
         lat_cnt <= 0;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Single transfer; both phases held until hready is seen high
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? wd : 32'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", hresp, 1'b0);
   endtask

   // Strobe in system clocks; hclk per system clock for {mult, div}
   function automatic int exp_sys(input logic [2:0] c, input logic [1:0] p);
      int t[8] = '{1, 3, 7, 11, 15, 19, 23, 27};
      return t[c] + int'(p[1]);
   endfunction
   function automatic int per(input logic [2:0] k);
      case (k[1:0])
         2'b00: return k[2] ? 1 : 2;
         2'b01: return 2;
         2'b10: return 4;
         default: return SP;
      endcase
   endfunction
   // Latch width in system clocks: page-hit cycle, one stretch wider for slow codes
   function automatic int exp_latch(input logic [2:0] c, input logic [1:0] p);
      int h[4] = '{1, 2, 4, 2};
      return h[p] + (c[2] ? 4 : 0);
   endfunction

   // Launch a move, optionally disturb it, poll until idle, check pins and status
   task automatic move(input logic [15:0] a, input logic [7:0] d, input logic wr, input logic [8:0] cfg,
                       input logic hit, input logic mid, output int act);
      logic [31:0] st;
      int l0, t0, n, b, p, q;
      l0 = latch_cnt;
      t0 = act_cnt;
      n = 0;
      b = exp_sys(cfg[2:0], cfg[4:3]);
      p = per(cfg[8:6]);
      q = exp_latch(cfg[2:0], cfg[4:3]);
      ahb(1'b1, xds_pkg::REG_ACCESS, {7'h0, wr, d, a}, st);
      if (mid) begin
         ahb(1'b1, xds_pkg::REG_CONFIG, {23'h0, cfg[8:3], 3'h0}, st);
         ahb(1'b1, xds_pkg::REG_ACCESS, 32'h0100_0000, st);
      end
      do begin
         ahb(1'b0, xds_pkg::REG_STATUS, 32'h0, st);
         n++;
      end while (st[0] !== 1'b0 && n < 1000);
      act = act_cnt - t0;
      check("busy", st[0], 1'b0);
      check("page_hit", st[1], hit);
      check("latch_pulses", latch_cnt - l0, !hit);
      check("strobe_sys", st[21:16], b);
      check("strobe_hclk", last_w > (b - 1) * p && last_w <= b * p, 1'b1);
      if (!hit) check("latch_hclk", last_l > (q - 1) * p && last_l <= q * p, 1'b1);
      if (!wr) check("read_data", st[15:8], d);
   endtask

   // Write miss, then a write and a read that hit when page mode is on, on one fresh page
   task automatic run_set(input logic [2:0] code, input logic [1:0] pts, input logic [2:0] clk,
                          input logic pe, input logic [7:0] dl);
      logic [31:0] r;
      logic [15:0] a;
      logic [7:0]  d;
      logic [8:0]  cfg;
      int          am, ah;
      cfg = {clk, pe, pts, code};
      page = page + 8'h01;
      a = {page, 8'($random(seed))};
      d = 8'($random(seed));
      dly <= dl;
      ahb(1'b1, xds_pkg::REG_CONFIG, {23'h0, cfg}, r);
      ahb(1'b0, xds_pkg::REG_CONFIG, 32'h0, r);
      check("config", r, {23'h0, cfg});
      move(a, ~d, 1'b1, cfg, 1'b0, 1'b0, am);
      move(a, d, 1'b1, cfg, pe, 1'b0, ah);
      check("hit_shorter", ah < am, pe);
      move(a, d, 1'b0, cfg, pe, 1'b0, ah);
   endtask

   // Main sequence
   initial begin
      logic [31:0] r;
      int          a;
      logic [2:0]  clks [5] = '{3'b100, 3'b000, 3'b001, 3'b010, 3'b011};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, xds_pkg::REG_CONFIG, 32'h0, r);
      check("config_reset", r, {23'h0, xds_pkg::CFG_RESET});
      ahb(1'b1, 8'h0c, 32'hffff_ffff, r);
      ahb(1'b0, 8'h0c, 32'h0, r);
      check("unmapped", r, 32'h0);
      $display("test reset done");
      for (int p = 0; p < 4; p++)
         for (int c = 0; c < 8; c++)
            run_set(3'(c), 2'(p), 3'b100, 1'b1, 8'($unsigned($random(seed)) % exp_sys(3'(c), 2'(p))));
      $display("test stretch table done");
      for (int k = 0; k < 5; k++)
         run_set(3'($random(seed)), 2'($random(seed)), clks[k], 1'b1, 8'h00);
      run_set(3'h5, 2'h1, 3'b100, 1'b0, 8'h00);
      $display("test clock and page modes done");
      // Setting change and a second launch while a slow move runs
      ahb(1'b1, xds_pkg::REG_CONFIG, 32'h0000_0127, r);
      move(16'h1234, 8'h5a, 1'b1, 9'h127, 1'b0, 1'b1, a);
      ahb(1'b0, xds_pkg::REG_ACCESS, 32'h0, r);
      check("access_kept", r[15:0], 16'h1234);
      move(16'h1234, 8'h5a, 1'b0, 9'h120, 1'b1, 1'b0, a);
      $display("test mid-move change done");
      report_and_stop();
   end

   // Watchdog
   initial begin
      #(5 * 80000);
      mismatches++;
      report_and_stop();
   end
endmodule

// ===== sim/xds_ext_ram.sv
`timescale 1ns/100ps
module xds_ext_ram (
   input  wire logic        hclk,
   input  wire logic [15:0] ext_addr,
   input  wire logic        ext_latch,
   input  wire logic        ext_rd_n,
   input  wire logic        ext_wr_n,
   input  wire logic [7:0]  ext_data_out,
   input  wire logic [7:0]  delay,
   output logic [7:0]       ext_data_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] page_r;
   logic [7:0] last_r = 8'h00;
   logic [7:0] wait_r = 8'h00;
   logic       drive;

   // Data valid only after the access delay; undriven bus shows inverted last value
   assign drive       = !ext_rd_n && (wait_r >= delay);
   assign ext_data_in = drive ? mem[{page_r, ext_addr[7:0]}] : ~last_r;

   // Upper byte lives in the latch, so a missed latch pulse corrupts the page
   always @(posedge hclk) begin
      if (ext_latch)
         page_r <= ext_addr[15:8];
      if (!ext_wr_n)
         mem[{page_r, ext_addr[7:0]}] <= ext_data_out;
      if (drive)
         last_r <= ext_data_in;
      wait_r <= ext_rd_n ? 8'h00 : wait_r + 8'h01;
   end
endmodule

// ===== sim/xds_top_checker.sv
`timescale 1ns/100ps
module xds_top_checker #(
   parameter int SLOW_PERIOD = 4096
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic [15:0] ext_addr,
   input wire logic        ext_latch,
   input wire logic        ext_rd_n,
   input wire logic        ext_wr_n,
   input wire logic [7:0]  ext_data_out,
   input wire logic        ext_data_oe
);
   logic [17:0] low_cnt_r;

   // Strobe width in hclk; a stuck strobe shows up as an overrun
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         low_cnt_r <= 18'h00000;
      else if (!ext_rd_n || !ext_wr_n)
         low_cnt_r <= low_cnt_r + 18'h00001;
      else
         low_cnt_r <= 18'h00000;
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Steps of a transfer as seen at the pins
   sequence s_rd_held; !ext_rd_n && !$past(ext_rd_n); endsequence
   sequence s_wr_held; !ext_wr_n && !$past(ext_wr_n); endsequence
   sequence s_rd_end; $rose(ext_rd_n); endsequence
   sequence s_wr_end; $rose(ext_wr_n); endsequence

   property p_latch_quiet; ext_latch |-> ext_rd_n && ext_wr_n && !ext_data_oe; endproperty
   property p_read_float; !ext_rd_n |-> !ext_data_oe && ext_wr_n; endproperty
   property p_write_drive; !ext_wr_n |-> ext_data_oe && ext_rd_n; endproperty
   property p_rd_stable; s_rd_held |-> $stable(ext_addr); endproperty
   property p_wr_stable; s_wr_held |-> $stable(ext_addr) && $stable(ext_data_out); endproperty
   property p_rd_hold; s_rd_end |-> $stable(ext_addr) && !ext_latch; endproperty
   property p_wr_hold; s_wr_end |-> ext_data_oe && $stable(ext_addr) && $stable(ext_data_out); endproperty
   property p_oe_release; $fell(ext_data_oe) |-> ext_wr_n && $past(ext_wr_n); endproperty
   property p_strobe_max; low_cnt_r <= 18'(28 * SLOW_PERIOD); endproperty

   a_latch_quiet: assert property (p_latch_quiet) else $error("strobe or data during latch");
   a_read_float: assert property (p_read_float) else $error("data driven during read");
   a_write_drive: assert property (p_write_drive) else $error("data not driven in write");
   a_rd_stable: assert property (p_rd_stable) else $error("address moved in read strobe");
   a_wr_stable: assert property (p_wr_stable) else $error("address or data moved in write");
   a_rd_hold: assert property (p_rd_hold) else $error("no read address hold");
   a_wr_hold: assert property (p_wr_hold) else $error("no write hold");
   a_oe_release: assert property (p_oe_release) else $error("data released without hold");
   a_strobe_max: assert property (p_strobe_max) else $error("strobe too long");
endmodule

bind xds_top xds_top_checker #(.SLOW_PERIOD(SLOW_PERIOD)) u_xds_top_checker (
   .hclk(hclk), .hresetn(hresetn), .ext_addr(ext_addr), .ext_latch(ext_latch), .ext_rd_n(ext_rd_n),
   .ext_wr_n(ext_wr_n), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe));
